// ---- hw/config_memory_crc_scrubber.sv ----
// configuration crc check and user mode background scrubber with error location
//
// Overview of operation
// - check crc of every loaded frame
// - store 16 check bits per frame
// - same polynomial in both checks
// - loop over all frames until reconfiguration
// - scrub only in user mode, enabled
// - checker tick is oscillator over 2..256
// - zero signature drives error low
// - non-zero signature starts location search
// - error output high on detected error
// - detect one, two, three flipped bits
// - locate single and double adjacent errors
// - location readable by jtag and core
// - new location overwrites unread one
// - always move on to next frame
// - ansi 16-bit crc generator
// - memory blocks and io flops unchecked
// - skip ram frames, hold error status
// - jtag writes 21-bit fault injection register
// - inject instruction only in user mode
// - injection type, byte location, byte value
`timescale 1ns/1ps
module config_memory_crc_scrubber
  import crc_scrub_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic reconfig_n_i,
  input wire logic ed_enable_i,
  input wire logic [DIV_SEL_W-1:0] div_sel_i,
  input wire logic [NUM_FRAMES-1:0] ram_frame_mask_i,
  input wire logic cfg_bit_valid_i,
  input wire logic cfg_bit_i,
  input wire logic cfg_check_valid_i,
  input wire logic [CRC_W-1:0] cfg_check_i,
  input wire logic core_loc_ack_i,
  input wire logic [IR_W-1:0] jtag_ir_i,
  input wire logic jtag_tck_i,
  input wire logic jtag_tdi_i,
  input wire logic jtag_capture_i,
  input wire logic jtag_update_i,
  output logic crc_error_o,
  output logic cfg_error_o,
  output logic user_mode_o,
  output err_loc_t loc_o,
  output logic loc_valid_o,
  output logic jtag_tdo_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  scrub_state_t state; // current state
  scrub_state_t next_state; // next state
  logic [BIT_IDX_W-1:0] bit_cnt; // shift order index
  logic [FRAME_IDX_W-1:0] frame_cnt; // current frame
  logic [FRAME_BITS-1:0] cell_mem [NUM_FRAMES]; // config cell memory
  logic [CRC_W-1:0] check_chain [NUM_FRAMES]; // stored check bits
  logic [CRC_W-1:0] crc; // engine result
  logic eng_clr; // engine clear
  logic eng_en; // engine step
  logic eng_bit; // engine data bit
  logic tick; // divided checker tick
  logic adv; // leave current frame
  logic [BIT_IDX_W-1:0] word_idx; // word bit being shifted
  logic rd_bit; // readback bit with injection
  logic [CRC_W-1:0] sig; // frame signature
  logic [CRC_W-1:0] cand; // syndrome of candidate bit
  logic [CRC_W-1:0] cand_next; // syndrome of next bit
  logic [BIT_IDX_W-1:0] wbit; // candidate word bit
  logic hit_single; // single bit match
  logic hit_double; // adjacent pair match
  logic [SYNC_W-1:0] sync1; // first sync stage
  logic [SYNC_W-1:0] sync2; // second sync stage
  logic [1:0] edge_d; // delayed capture, update
  logic tck_rise; // jtag clock edge
  logic cap_rise; // jtag capture edge
  logic upd_rise; // jtag update edge
  logic reconfig_n; // synchronised reconfiguration
  logic [IR_W-1:0] ir; // synchronised instruction
  logic [INJ_W-1:0] jtag_shift; // jtag data shift register
  inj_reg_t inj_pending; // written by jtag, not yet applied
  logic inj_pend_flag; // pending injection present
  inj_reg_t inj_active; // injection used in first frame
  logic [FRAME_BITS-1:0] inj_mask; // bits flipped on readback

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  // one engine serves both checks
  crc16_engine u_engine (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .clr_i(eng_clr),
    .en_i(eng_en),
    .bit_i(eng_bit),
    .crc_o(crc)
  );

  // tick rate is oscillator over 2..256
  check_clk_div u_div (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .div_sel_i(div_sel_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops before use, third only for edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reconfig stage starts at its idle high level, no restart after reset
      sync1 <= {{(SYNC_W-1){1'b0}}, 1'b1};
      sync2 <= {{(SYNC_W-1){1'b0}}, 1'b1};
      edge_d <= '0;
    end else if (ce_i) begin
      sync1 <= {jtag_ir_i, jtag_update_i, jtag_capture_i, jtag_tdi_i, reconfig_n_i};
      sync2 <= sync1;
      edge_d <= {sync2[3], sync2[2]};
    end
  end

  // tck lives outside the packed vector to keep edges apart
  logic [1:0] tck_s; // tck sync stages
  logic tck_d; // tck delayed for edge

  // tck sync chain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tck_s <= '0;
      tck_d <= 1'b0;
    end else if (ce_i) begin
      tck_s <= {tck_s[0], jtag_tck_i};
      tck_d <= tck_s[1];
    end
  end

  always_comb begin
    reconfig_n = sync2[0];
    ir = sync2[SYNC_W-1:4];
    tck_rise = tck_s[1] & ~tck_d;
    cap_rise = sync2[2] & ~edge_d[0];
    upd_rise = sync2[3] & ~edge_d[1];
  end

  // ----------------------------------------------------------------
  // readback path with fault injection
  // ----------------------------------------------------------------
  // frame word shifted msb first
  always_comb begin
    word_idx = BIT_LAST - bit_cnt;
    rd_bit = cell_mem[frame_cnt][word_idx] ^ inj_mask[word_idx];
  end

  // per byte flip mask from type and location
  genvar gb;
  generate
    for (gb = 0; gb < BYTES; gb++) begin : g_inj
      logic [BYTE_SEL_W-1:0] sel; // selected byte
      logic hit; // this byte is flipped
      always_comb begin
        sel = inj_active.byte_loc[BYTE_SEL_W-1:0];
        hit = 1'b0;
        if (frame_cnt == FRAME_FIRST) begin
          if (inj_active.itype == INJ_SINGLE) begin
            hit = (sel == BYTE_SEL_W'(gb));
          end else if (inj_active.itype == INJ_DOUBLE) begin
            hit = (sel == BYTE_SEL_W'(gb)) || (BYTE_SEL_W'(sel + 2'h1) == BYTE_SEL_W'(gb));
          end
        end
        inj_mask[gb*8 +: 8] = hit ? inj_active.value : 8'h00;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // next state and engine control
  always_comb begin
    next_state = state;
    eng_clr = 1'b0;
    eng_en = 1'b0;
    eng_bit = 1'b0;
    adv = 1'b0;
    case (state)
      ST_CFG_LOAD: begin
        eng_en = cfg_bit_valid_i;
        eng_bit = cfg_bit_i;
        if (cfg_bit_valid_i && bit_cnt == BIT_LAST) begin
          next_state = ST_CFG_CHECK;
        end
      end
      ST_CFG_CHECK: begin
        if (cfg_check_valid_i) begin
          eng_clr = 1'b1;
          if (crc != cfg_check_i) begin
            next_state = ST_CFG_FAIL;
          end else if (frame_cnt == FRAME_LAST) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_CFG_LOAD;
          end
        end
      end
      ST_CFG_FAIL: begin
        next_state = ST_CFG_FAIL;
      end
      ST_IDLE: begin
        // start only when enabled in user mode
        if (ed_enable_i) begin
          eng_clr = 1'b1;
          next_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (tick) begin
          if (ram_frame_mask_i[frame_cnt]) begin
            adv = 1'b1;
          end else begin
            eng_en = 1'b1;
            eng_bit = rd_bit;
            if (bit_cnt == BIT_LAST) begin
              next_state = ST_EVAL;
            end
          end
        end
      end
      ST_EVAL: begin
        if (sig == CRC_ZERO) begin
          adv = 1'b1;
        end else begin
          next_state = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (tick && (hit_single || hit_double || wbit == BIT_LAST)) begin
          adv = 1'b1;
        end
      end
      default: begin
        next_state = ST_CFG_LOAD;
      end
    endcase
    if (adv) begin
      eng_clr = 1'b1;
      next_state = ed_enable_i ? ST_SCAN : ST_IDLE;
    end
    // engine held clear while reconfiguration is requested
    if (!reconfig_n) begin
      eng_clr = 1'b1;
      eng_en = 1'b0;
    end
  end

  // state, bit and frame counters
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_CFG_LOAD;
      bit_cnt <= BIT_FIRST;
      frame_cnt <= FRAME_FIRST;
    end else if (ce_i) begin
      if (!reconfig_n) begin
        // restart configuration
        state <= ST_CFG_LOAD;
        bit_cnt <= BIT_FIRST;
        frame_cnt <= FRAME_FIRST;
      end else begin
        state <= next_state;
        if (eng_en) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
        if (eng_clr) begin
          bit_cnt <= BIT_FIRST;
        end
        if (state == ST_CFG_CHECK && cfg_check_valid_i && crc == cfg_check_i && frame_cnt != FRAME_LAST) begin
          frame_cnt <= frame_cnt + 3'h1;
        end else if (state == ST_CFG_CHECK && next_state == ST_IDLE) begin
          frame_cnt <= FRAME_FIRST;
        end else if (adv) begin
          frame_cnt <= frame_cnt + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // only config cells are held, no memory or io
  always_ff @(posedge clk_i) begin
    if (ce_i && reconfig_n && state == ST_CFG_LOAD && cfg_bit_valid_i) begin
      cell_mem[frame_cnt][word_idx] <= cfg_bit_i;
    end
  end

  // 16-bit check chain, one word per frame
  always_ff @(posedge clk_i) begin
    if (ce_i && state == ST_CFG_CHECK && cfg_check_valid_i && crc == cfg_check_i) begin
      check_chain[frame_cnt] <= crc;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // any change of up to three bits gives non-zero signature
  always_comb begin
    sig = crc ^ check_chain[frame_cnt];
  end

  // error, config error and user mode flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_error_o <= 1'b0;
      cfg_error_o <= 1'b0;
      user_mode_o <= 1'b0;
    end else if (ce_i) begin
      if (!reconfig_n) begin
        crc_error_o <= 1'b0;
        cfg_error_o <= 1'b0;
        user_mode_o <= 1'b0;
      end else begin
        if (state == ST_EVAL) begin
          crc_error_o <= (sig != CRC_ZERO);
        end
        if (next_state == ST_CFG_FAIL) begin
          cfg_error_o <= 1'b1;
        end
        if (state == ST_CFG_CHECK && next_state == ST_IDLE) begin
          user_mode_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // error location search
  // ----------------------------------------------------------------
  // syndrome walk with the ansi polynomial
  always_comb begin
    cand_next = crc_step(cand, 1'b0);
    hit_single = (sig == cand);
    hit_double = (wbit != BIT_LAST) && (sig == (cand ^ cand_next));
  end

  // candidate syndrome and bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cand <= CRC_ZERO;
      wbit <= BIT_FIRST;
    end else if (ce_i) begin
      if (state == ST_EVAL) begin
        cand <= CRC_POLY;
        wbit <= BIT_FIRST;
      end else if (state == ST_SEARCH && tick) begin
        cand <= cand_next;
        wbit <= wbit + 5'h01;
      end
    end
  end

  // record type and location of the found error
  // a new record overwrites an unread one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loc_o <= '0;
      loc_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (!reconfig_n) begin
        loc_o <= '0;
        loc_valid_o <= 1'b0;
      end else if (state == ST_SEARCH && adv) begin
        loc_o.frame <= frame_cnt;
        loc_o.bit_pos <= wbit;
        loc_o.etype <= hit_single ? ERR_SINGLE : (hit_double ? ERR_DOUBLE_ADJ : ERR_UNKNOWN);
        // set wins over a read in the same cycle
        loc_valid_o <= 1'b1;
      end else if (core_loc_ack_i || (cap_rise && ir == IR_READ_LOC)) begin
        loc_valid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // jtag access
  // ----------------------------------------------------------------
  // location shifted out over jtag
  // injection data shifted in over jtag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jtag_shift <= '0;
      jtag_tdo_o <= 1'b0;
    end else if (ce_i) begin
      if (cap_rise && ir == IR_READ_LOC) begin
        jtag_shift <= INJ_W'(loc_o);
      end else if (tck_rise && (ir == IR_READ_LOC || ir == IR_FAULT_INJECT)) begin
        jtag_shift <= {sync2[1], jtag_shift[INJ_W-1:1]};
        jtag_tdo_o <= jtag_shift[0];
      end
    end
  end

  // injection accepted only in user mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inj_pending <= '0;
      inj_pend_flag <= 1'b0;
      inj_active <= '0;
    end else if (ce_i) begin
      if (!reconfig_n) begin
        inj_pend_flag <= 1'b0;
        inj_active <= '0;
      end else begin
        if (upd_rise && ir == IR_FAULT_INJECT && user_mode_o) begin
          inj_pending <= inj_reg_t'(jtag_shift);
          inj_pend_flag <= 1'b1;
        end else if (adv && frame_cnt == FRAME_LAST) begin
          inj_pend_flag <= 1'b0;
        end
        // type 11 decodes as no injection
        if (adv && frame_cnt == FRAME_LAST && inj_pend_flag) begin
          inj_active <= inj_pending;
        end else if (adv && frame_cnt == FRAME_FIRST) begin
          inj_active <= '0;
        end
      end
    end
  end
endmodule

// ---- hw/crc_scrub_pkg.sv ----
// shared constants, types and crc step function for the config memory crc scrubber
package crc_scrub_pkg;
  // ----------------------------------------------------------------
  // geometry of the config cell memory
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32; // bits per frame
  localparam int NUM_FRAMES = 8; // frames in the device
  localparam int BIT_IDX_W = 5; // bit index width
  localparam int FRAME_IDX_W = 3; // frame index width
  localparam int CRC_W = 16; // check bits per frame
  localparam logic [BIT_IDX_W-1:0] BIT_LAST = 5'h1F; // last bit index
  localparam logic [BIT_IDX_W-1:0] BIT_FIRST = 5'h00; // first bit index
  localparam logic [FRAME_IDX_W-1:0] FRAME_LAST = 3'h7; // last frame index
  localparam logic [FRAME_IDX_W-1:0] FRAME_FIRST = 3'h0; // first frame index
  // ----------------------------------------------------------------
  // crc polynomial x^16 + x^15 + x^2 + 1
  // ----------------------------------------------------------------
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005; // generator taps
  localparam logic [CRC_W-1:0] CRC_ZERO = 16'h0000; // clean signature
  // ----------------------------------------------------------------
  // checker clock divider
  // ----------------------------------------------------------------
  localparam int OSC_MHZ = 100; // internal oscillator rate
  localparam int DIV_SEL_W = 3; // select 0..7 means divide by 2..256
  localparam int DIV_CNT_W = 8; // divider counter width
  localparam logic [DIV_CNT_W-1:0] DIV_BASE_MASK = 8'h01; // divide by two mask
  // ----------------------------------------------------------------
  // jtag instructions and fault injection layout
  // ----------------------------------------------------------------
  localparam int IR_W = 10; // instruction width
  localparam logic [IR_W-1:0] IR_FAULT_INJECT = 10'h015; // fault_inject_instr
  localparam logic [IR_W-1:0] IR_READ_LOC = 10'h016; // read_error_location_instr
  localparam int INJ_W = 21; // fault injection register width
  localparam logic [1:0] INJ_NONE = 2'h0; // no injection
  localparam logic [1:0] INJ_SINGLE = 2'h1; // single byte
  localparam logic [1:0] INJ_DOUBLE = 2'h2; // double adjacent byte
  localparam int BYTES = 4; // bytes per frame
  localparam int BYTE_SEL_W = 2; // byte select width
  // ----------------------------------------------------------------
  // error types and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] ERR_NONE = 2'h0; // nothing found
  localparam logic [1:0] ERR_SINGLE = 2'h1; // single bit
  localparam logic [1:0] ERR_DOUBLE_ADJ = 2'h2; // two adjacent bits
  localparam logic [1:0] ERR_UNKNOWN = 2'h3; // not located
  localparam int SYNC_W = 14; // synchronised pin count
  typedef struct packed {
    logic [FRAME_IDX_W-1:0] frame; // failing frame
    logic [BIT_IDX_W-1:0] bit_pos; // word bit of first flipped bit
    logic [1:0] etype; // error type
  } err_loc_t;
  localparam int LOC_W = $bits(err_loc_t); // location record width
  typedef struct packed {
    logic [1:0] itype; // injection type
    logic [10:0] byte_loc; // byte location
    logic [7:0] value; // error byte value
  } inj_reg_t;
  typedef enum logic [6:0] {
    ST_CFG_LOAD = 7'h01,
    ST_CFG_CHECK = 7'h02,
    ST_CFG_FAIL = 7'h04,
    ST_IDLE = 7'h08,
    ST_SCAN = 7'h10,
    ST_EVAL = 7'h20,
    ST_SEARCH = 7'h40
  } scrub_state_t;
  // one msb-first crc step
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
    logic fb;
    fb = c[CRC_W-1] ^ b;
    crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_ZERO);
  endfunction
endpackage

// ---- hw/crc16_engine.sv ----
// serial 16-bit crc engine shared by configuration and background check
`timescale 1ns/1ps
module crc16_engine
  import crc_scrub_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic bit_i,
  output logic [CRC_W-1:0] crc_o
);
  // ----------------------------------------------------------------
  // crc register
  // ----------------------------------------------------------------
  // clear wins over a step
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_o <= CRC_ZERO;
    end else if (ce_i) begin
      if (clr_i) begin
        crc_o <= CRC_ZERO;
      end else if (en_i) begin
        crc_o <= crc_step(crc_o, bit_i);
      end
    end
  end
endmodule

// ---- hw/check_clk_div.sv ----
// power-of-two divider making the checker tick
`timescale 1ns/1ps
module check_clk_div
  import crc_scrub_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [DIV_SEL_W-1:0] div_sel_i,
  output logic tick_o
);
  logic [DIV_CNT_W-1:0] cnt; // free running count
  logic [DIV_CNT_W-1:0] mask; // low bits that must be all ones

  // mask selects divide by 2 to 256
  always_comb begin
    mask = (DIV_BASE_MASK << div_sel_i) | ((DIV_BASE_MASK << div_sel_i) - DIV_BASE_MASK);
  end

  // ----------------------------------------------------------------
  // counter and tick
  // ----------------------------------------------------------------
  // one tick per divided period
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= cnt + DIV_BASE_MASK;
      tick_o <= ((cnt & mask) == mask);
    end
  end
endmodule

// ---- verif/config_memory_crc_scrubber_props.sv ----
// assertion checker for the config memory crc scrubber
`timescale 1ns/1ps
module config_memory_crc_scrubber_props
  import crc_scrub_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic reconfig_n_i,
  input wire logic cfg_check_valid_i,
  input wire logic core_loc_ack_i,
  input wire logic crc_error_o,
  input wire logic cfg_error_o,
  input wire logic user_mode_o,
  input wire err_loc_t loc_o,
  input wire logic loc_valid_o
);
  // recent reconfig pin history, covers the sync delay
  logic [3:0] rc_hist;
  logic rc_ok;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_hist <= 4'h0;
    end else begin
      rc_hist <= {rc_hist[2:0], reconfig_n_i};
    end
  end
  assign rc_ok = (&rc_hist) & reconfig_n_i;
  a_cfg_fail_excl: assert property (cfg_error_o |-> !user_mode_o)
    else $error("config failure together with user mode");
  a_cfg_err_cause: assert property ($rose(cfg_error_o) |-> $past(cfg_check_valid_i))
    else $error("config error without a check word");
  a_user_entry: assert property ($rose(user_mode_o) |-> $past(cfg_check_valid_i))
    else $error("user mode entered without a check word");
  a_cfg_err_hold: assert property (cfg_error_o && rc_ok |=> cfg_error_o)
    else $error("config error dropped without reconfig");
  a_user_hold: assert property (user_mode_o && rc_ok |=> user_mode_o)
    else $error("user mode dropped without reconfig");
  a_scrub_user_only: assert property (crc_error_o |-> user_mode_o)
    else $error("scrub error outside user mode");
  a_loc_after_err: assert property ($rose(loc_valid_o) |-> crc_error_o && user_mode_o)
    else $error("location record without error output");
  a_ack_clears: assert property (loc_valid_o && core_loc_ack_i && ce_i |=> !loc_valid_o)
    else $error("core read did not clear location valid");
  a_etype_set: assert property (loc_valid_o |-> loc_o.etype != ERR_NONE)
    else $error("location record with no error type");
  c_user: cover property ($rose(user_mode_o));
  c_cfg_fail: cover property ($rose(cfg_error_o));
  c_loc: cover property ($rose(loc_valid_o));
endmodule

bind config_memory_crc_scrubber config_memory_crc_scrubber_props u_config_memory_crc_scrubber_props (.clk_i,
  .arst_n_i, .ce_i, .reconfig_n_i, .cfg_check_valid_i, .core_loc_ack_i, .crc_error_o, .cfg_error_o,
  .user_mode_o, .loc_o, .loc_valid_o);

// ---- verif/loc_reader_model.sv ----
// core side reader that acknowledges error location records
`timescale 1ns/1ps
module loc_reader_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] delay_i,
  input wire logic loc_valid_i,
  output logic ack_o
);
  int cnt = 0;
  initial ack_o = 1'b0;
  // one-cycle read after a chosen delay
  always @(negedge clk_i) begin
    if (en_i && loc_valid_i === 1'b1 && !ack_o) begin
      ack_o <= (cnt >= delay_i);
      cnt <= cnt + 1;
    end else begin
      ack_o <= 1'b0;
      cnt <= 0;
    end
  end
endmodule

// ---- verif/test_config_memory_crc_scrubber.sv ----
// self-checking bench for the config memory crc scrubber
`timescale 1ns/1ps
module test_config_memory_crc_scrubber import crc_scrub_pkg::*;;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic reconfig_n_i = 1'b1;
  logic ed_enable_i = 1'b0;
  logic cfg_bit_valid_i = 1'b0;
  logic cfg_bit_i = 1'b0;
  logic cfg_check_valid_i = 1'b0;
  logic [CRC_W-1:0] cfg_check_i = 16'h0000;
  logic [IR_W-1:0] jtag_ir_i = 10'h000;
  logic jtag_tck_i = 1'b0;
  logic jtag_tdi_i = 1'b0;
  logic jtag_capture_i = 1'b0;
  logic jtag_update_i = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] rd_dly = 4'h3;
  logic [DIV_SEL_W-1:0] div_sel = 3'h0;
  logic ack, crc_error_o, cfg_error_o, user_mode_o, loc_valid_o, jtag_tdo_o, seen;
  err_loc_t loc_o;
  logic [LOC_W-1:0] rd;
  int num_errors = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  config_memory_crc_scrubber u_config_memory_crc_scrubber (.clk_i, .arst_n_i, .ce_i(1'b1), .reconfig_n_i,
    .ed_enable_i, .div_sel_i(div_sel), .ram_frame_mask_i(8'h02), .cfg_bit_valid_i, .cfg_bit_i,
    .cfg_check_valid_i, .cfg_check_i, .core_loc_ack_i(ack), .jtag_ir_i, .jtag_tck_i, .jtag_tdi_i,
    .jtag_capture_i, .jtag_update_i, .crc_error_o, .cfg_error_o, .user_mode_o, .loc_o, .loc_valid_o,
    .jtag_tdo_o);
  loc_reader_model u_loc_reader_model (.clk_i, .en_i(rd_en), .delay_i(rd_dly), .loc_valid_i(loc_valid_o),
    .ack_o(ack));
  // msb-first crc, zero seed
  function automatic logic [15:0] crc_of(input logic [31:0] w);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // load all frames, frame bad gets a wrong check word
  task automatic load(input int bad);
    logic [31:0] w;
    for (int f = 0; f < NUM_FRAMES; f++) begin
      w = {5'h0A, f[2:0], 24'h5A0F3C};
      for (int i = 31; i >= 0; i--) begin
        cyc(1);
        cfg_check_valid_i = 1'b0;
        cfg_bit_valid_i = 1'b1;
        cfg_bit_i = w[i];
      end
      cyc(1);
      cfg_bit_valid_i = 1'b0;
      cfg_check_valid_i = 1'b1;
      cfg_check_i = crc_of(w) ^ ((f == bad) ? 16'h0001 : 16'h0000);
    end
    cyc(1);
    cfg_check_valid_i = 1'b0;
    cyc(1);
  endtask
  task automatic pulse_tck();
    jtag_tck_i = 1'b1;
    cyc(4);
    jtag_tck_i = 1'b0;
    cyc(4);
  endtask
  task automatic inject(input logic [INJ_W-1:0] v);
    jtag_ir_i = IR_FAULT_INJECT;
    cyc(4);
    for (int i = 0; i < INJ_W; i++) begin
      jtag_tdi_i = v[i];
      pulse_tck();
    end
    jtag_update_i = 1'b1;
    cyc(4);
    jtag_update_i = 1'b0;
    cyc(4);
  endtask
  task automatic wait_loc();
    for (int n = 0; n < 3000 && loc_valid_o !== 1'b1; n++) cyc(1);
    chk(loc_valid_o, 1'b1);
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
  initial begin
    cyc(16);
    arst_n_i = 1'b1;
    cyc(1);
    load(3);
    chk(cfg_error_o, 1'b1);
    chk(user_mode_o, 1'b0);
    reconfig_n_i = 1'b0;
    cyc(4);
    reconfig_n_i = 1'b1;
    cyc(4);
    chk(cfg_error_o, 1'b0);
    load(-1);
    chk(user_mode_o, 1'b1);
    ed_enable_i = 1'b1;
    rd_en = 1'b1;
    seen = 1'b0;
    repeat (2000) begin
      cyc(1);
      seen = seen | crc_error_o | loc_valid_o;
    end
    chk(seen, 1'b0);
    inject({INJ_SINGLE, 11'h001, 8'h10});
    wait_loc();
    chk(crc_error_o, 1'b1);
    chk(loc_o.frame, FRAME_FIRST);
    chk(loc_o.etype, ERR_SINGLE);
    chk(loc_o.bit_pos, 5'h0C);
    cyc(20);
    chk(loc_valid_o, 1'b0);
    for (int n = 0; n < 1000 && crc_error_o !== 1'b0; n++) cyc(1);
    chk(crc_error_o, 1'b0);
    rd_en = 1'b0;
    inject({INJ_SINGLE, 11'h000, 8'h03});
    wait_loc();
    jtag_ir_i = IR_READ_LOC;
    cyc(4);
    jtag_capture_i = 1'b1;
    cyc(4);
    jtag_capture_i = 1'b0;
    cyc(4);
    chk(loc_valid_o, 1'b0);
    for (int i = 0; i < LOC_W; i++) begin
      pulse_tck();
      rd[i] = jtag_tdo_o;
    end
    chk(rd[1:0], ERR_DOUBLE_ADJ);
    chk(rd[6:2], BIT_FIRST);
    chk(rd[9:7], FRAME_FIRST);
    rd_en = 1'b1;
    rd_dly = 4'hA;
    div_sel = 3'h1;
    for (int k = 2; k < 4; k++) begin
      seen = 1'b0;
      inject({k[1:0], 11'h000, 8'h01});
      repeat (2500) begin
        cyc(1);
        seen = seen | crc_error_o;
      end
      chk(seen, k == 2);
    end
    reconfig_n_i = 1'b0;
    cyc(4);
    chk(user_mode_o, 1'b0);
    conclude();
  end
endmodule
